/* File: core/sep_params.svh */
// Constants of the serial EEPROM command and protection block
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH

// One-byte opcodes, shifted in most significant bit first
`define SEP_OP_LATCH_SET    8'h06
`define SEP_OP_LATCH_CLEAR  8'h04
`define SEP_OP_STATUS_READ  8'h05
`define SEP_OP_STATUS_WRITE 8'h01
`define SEP_OP_ARRAY_READ   8'h03
`define SEP_OP_ARRAY_WRITE  8'h02

// Bits per serial byte and frame lengths in bytes
`define SEP_BITS_PER_BYTE   4'h8
`define SEP_BYTES_CMD       3'h1
`define SEP_BYTES_STATUS_WR 3'h2
`define SEP_BYTES_ARRAY_WR  3'h4
`define SEP_BYTES_MAX       3'h7

// Decoded array address width
`define SEP_ADDR_W          12

// Status byte field positions
`define SEP_ST_WIP          0
`define SEP_ST_WEL          1
`define SEP_ST_BP_LOW       2
`define SEP_ST_BP_HIGH      3
`define SEP_ST_LOCK         7

// Block-protect codes and the lowest protected address of each code other than SEP_BP_NONE
`define SEP_BP_NONE         2'h0
`define SEP_BP_QUARTER      2'h1
`define SEP_BP_HALF         2'h2
`define SEP_BP_ALL          2'h3
`define SEP_PROT_QUARTER    12'hC00
`define SEP_PROT_HALF       12'h800
`define SEP_PROT_ALL        12'h000

// Default self-timed programming cycle length in clk_sys cycles
`define SEP_WRITE_CYCLES    32'h0000_03E8

`endif

/* File: core/sep_pkg.sv */
// Types of the serial EEPROM command and protection block
package sep_pkg;

  typedef enum logic [2:0] {
    SEP_IDLE      = 3'h1,
    SEP_BUSY_ARR  = 3'h2,
    SEP_BUSY_STAT = 3'h4
  } sep_state_type;

  // Everything the link side gathers during one select frame
  typedef struct packed {
    logic [7:0] shreg;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic       bad;
  } sep_frame_type;

  // Non-volatile part of the status byte
  typedef struct packed {
    logic       lock;
    logic [1:0] bp;
  } sep_nv_type;

endpackage

/* File: core/sep_cmd_protect.sv */
// Command decoder, status byte and write protection of a serial EEPROM
`include "sep_params.svh"

module sep_cmd_protect
  import sep_pkg::*;
#(
  parameter int unsigned write_cycle_len = `SEP_WRITE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic wp_n,
  input wire logic nv_clear,
  output logic sdo,
  output logic sdo_oe,
  output logic [7:0] status,
  output logic hardware_lock_mode,
  output logic mem_wr_start,
  output logic [`SEP_ADDR_W-1:0] mem_wr_addr,
  output logic [7:0] mem_wr_data
);

  // Opcode in the command set
  function automatic logic op_valid(input logic [7:0] op);
    op_valid = (op == `SEP_OP_LATCH_SET) || (op == `SEP_OP_LATCH_CLEAR) ||
               (op == `SEP_OP_STATUS_READ) || (op == `SEP_OP_STATUS_WRITE) ||
               (op == `SEP_OP_ARRAY_READ) || (op == `SEP_OP_ARRAY_WRITE);
  endfunction

  // Address lies in the read-only region chosen by the protect bits
  function automatic logic addr_protected(input logic [1:0] bp,
                                          input logic [`SEP_ADDR_W-1:0] addr);
    unique case (bp)
      `SEP_BP_NONE: addr_protected = 1'b0;
      `SEP_BP_QUARTER: addr_protected = addr >= `SEP_PROT_QUARTER;
      `SEP_BP_HALF: addr_protected = addr >= `SEP_PROT_HALF;
      `SEP_BP_ALL: addr_protected = addr >= `SEP_PROT_ALL;
    endcase
  endfunction

  // Link side, rising serial clock: shift in one frame
  logic fresh;
  logic frame_tog;
  logic next_frame_tog;
  sep_frame_type fr;
  sep_frame_type next_fr;

  // Select high marks the next rising edge as the first of a frame.
  // Link clock is idle during srst, so srst may clear the link flops directly.
  always_ff @(posedge sck or posedge cs_n or posedge srst) begin
    if (cs_n || srst) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  always_comb begin
    sep_frame_type base;
    logic [7:0] shifted;
    shifted = 8'h00;
    base = fr;
    next_frame_tog = frame_tog;
    if (fresh) begin
      base = '0;
      next_frame_tog = ~frame_tog;
    end
    next_fr = base;
    shifted = {base.shreg[6:0], sdi};
    if (!base.bad) begin
      next_fr.shreg = shifted;
      next_fr.bit_cnt = base.bit_cnt + 3'h1;
      if (base.bit_cnt == 3'h7) begin
        if (base.byte_cnt != `SEP_BYTES_MAX) begin
          next_fr.byte_cnt = base.byte_cnt + 3'h1;
        end
        unique case (base.byte_cnt)
          3'h0: begin
            next_fr.opcode = shifted;
            next_fr.bad = !op_valid(shifted);
          end
          3'h1: next_fr.byte1 = shifted;
          3'h2: next_fr.byte2 = shifted;
          3'h3: next_fr.byte3 = shifted;
          default: next_fr.byte3 = base.byte3;
        endcase
      end
    end
  end

  always_ff @(posedge sck) begin
    fr <= next_fr;
  end

  // Toggle needs a known start, or no frame end is ever seen
  always_ff @(posedge sck or posedge srst) begin
    if (srst) begin
      frame_tog <= 1'b0;
    end else begin
      frame_tog <= next_frame_tog;
    end
  end

  // Link side, falling serial clock: status byte out
  logic [7:0] stat_meta;
  logic [7:0] stat_sync;
  logic [7:0] next_stat_meta;
  logic [7:0] next_stat_sync;
  logic next_sdo;
  logic next_sdo_oe;
  logic [7:0] stat_snap;
  logic [7:0] next_stat_snap;

  always_comb begin
    next_stat_meta = status;
    next_stat_sync = stat_meta;
    next_stat_snap = stat_snap;
    next_sdo = 1'b0;
    next_sdo_oe = 1'b0;
    // After the opcode the status byte repeats while select stays low
    if (!fresh && !fr.bad && fr.byte_cnt != 3'h0 &&
        fr.opcode == `SEP_OP_STATUS_READ) begin
      if (fr.bit_cnt == 3'h0) begin
        // Whole byte frozen at its first bit so a flag change cannot tear it
        next_stat_snap = stat_sync;
        next_sdo = stat_sync[~fr.bit_cnt];
      end else begin
        next_sdo = stat_snap[~fr.bit_cnt];
      end
      next_sdo_oe = 1'b1;
    end
  end

  always_ff @(negedge sck or posedge cs_n or posedge srst) begin
    if (cs_n || srst) begin
      stat_meta <= 8'h00;
      stat_sync <= 8'h00;
      stat_snap <= 8'h00;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      stat_meta <= next_stat_meta;
      stat_sync <= next_stat_sync;
      stat_snap <= next_stat_snap;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
    end
  end

  // System side: pin and frame toggle synchronisers
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic wp_meta;
  logic wp_sync;
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  logic next_tog_seen;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
    end else begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      wp_meta <= wp_n;
      wp_sync <= wp_meta;
      tog_meta <= frame_tog;
      tog_sync <= tog_meta;
    end
  end

  // System side: command execution and programming cycle
  sep_state_type state;
  sep_state_type next_state;
  logic [31:0] cyc_cnt;
  logic [31:0] next_cyc_cnt;
  logic write_enable_latch;
  logic next_wel;
  logic write_cycle_active;
  logic next_wip;
  sep_nv_type nv;
  sep_nv_type next_nv;
  sep_nv_type nv_pend;
  sep_nv_type next_nv_pend;
  logic [7:0] next_status;
  logic next_lock_mode;
  logic next_wr_start;
  logic [`SEP_ADDR_W-1:0] next_wr_addr;
  logic [7:0] next_wr_data;

  always_comb begin
    logic frame_end;
    logic on_boundary;
    logic [`SEP_ADDR_W-1:0] addr;
    logic locked;
    frame_end = cs_sync && !cs_prev && (tog_sync != tog_seen);
    // Frame is stable here: no serial edges while deselected
    on_boundary = (fr.bit_cnt == 3'h0) && !fr.bad;
    addr = {fr.byte1[3:0], fr.byte2};
    locked = nv.lock && !wp_sync;
    next_tog_seen = frame_end ? tog_sync : tog_seen;
    next_state = state;
    next_cyc_cnt = cyc_cnt;
    next_wel = write_enable_latch;
    next_wip = write_cycle_active;
    next_nv = nv;
    next_nv_pend = nv_pend;
    next_wr_start = 1'b0;
    next_wr_addr = mem_wr_addr;
    next_wr_data = mem_wr_data;
    unique case (state)
      SEP_IDLE: begin
        if (frame_end && on_boundary) begin
          unique case (fr.opcode)
            `SEP_OP_LATCH_SET: begin
              if (fr.byte_cnt == `SEP_BYTES_CMD) begin
                next_wel = 1'b1;
              end
            end
            `SEP_OP_LATCH_CLEAR: begin
              if (fr.byte_cnt == `SEP_BYTES_CMD) begin
                next_wel = 1'b0;
              end
            end
            `SEP_OP_STATUS_WRITE: begin
              if (fr.byte_cnt == `SEP_BYTES_STATUS_WR && write_enable_latch && !locked) begin
                next_nv_pend.lock = fr.byte1[`SEP_ST_LOCK];
                next_nv_pend.bp = fr.byte1[`SEP_ST_BP_HIGH:`SEP_ST_BP_LOW];
                next_state = SEP_BUSY_STAT;
                next_wip = 1'b1;
                next_cyc_cnt = 32'h0000_0000;
              end
            end
            `SEP_OP_ARRAY_WRITE: begin
              if (fr.byte_cnt >= `SEP_BYTES_ARRAY_WR && write_enable_latch &&
                  !addr_protected(nv.bp, addr)) begin
                next_wr_start = 1'b1;
                next_wr_addr = addr;
                next_wr_data = fr.byte3;
                next_state = SEP_BUSY_ARR;
                next_wip = 1'b1;
                next_cyc_cnt = 32'h0000_0000;
              end
            end
            default: next_wel = write_enable_latch;
          endcase
        end
      end
      SEP_BUSY_ARR, SEP_BUSY_STAT: begin
        // Commands other than status read that end during the cycle are dropped, not run afterwards
        if (cyc_cnt == write_cycle_len - 32'h1) begin
          if (state == SEP_BUSY_STAT) begin
            next_nv = nv_pend;
          end
          next_wel = 1'b0;
          next_wip = 1'b0;
          next_state = SEP_IDLE;
        end else begin
          next_cyc_cnt = cyc_cnt + 32'h1;
        end
      end
      default: next_state = SEP_IDLE;
    endcase
    if (nv_clear) begin
      next_nv = '0;
    end
    next_status = 8'h00;
    next_status[`SEP_ST_WIP] = write_cycle_active;
    next_status[`SEP_ST_WEL] = write_enable_latch;
    next_status[`SEP_ST_BP_LOW] = nv.bp[0];
    next_status[`SEP_ST_BP_HIGH] = nv.bp[1];
    next_status[`SEP_ST_LOCK] = nv.lock;
    next_lock_mode = locked;
  end

  // Power-up reset leaves the non-volatile bits alone
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= SEP_IDLE;
      cyc_cnt <= 32'h0000_0000;
      write_enable_latch <= 1'b0;
      write_cycle_active <= 1'b0;
      nv_pend <= '0;
      tog_seen <= 1'b0;
      status <= 8'h00;
      hardware_lock_mode <= 1'b0;
      mem_wr_start <= 1'b0;
      mem_wr_addr <= '0;
      mem_wr_data <= 8'h00;
    end else begin
      state <= next_state;
      cyc_cnt <= next_cyc_cnt;
      write_enable_latch <= next_wel;
      write_cycle_active <= next_wip;
      nv_pend <= next_nv_pend;
      tog_seen <= next_tog_seen;
      status <= next_status;
      hardware_lock_mode <= next_lock_mode;
      mem_wr_start <= next_wr_start;
      mem_wr_addr <= next_wr_addr;
      mem_wr_data <= next_wr_data;
    end
  end

  // Non-volatile bits: only a completed status write or nv_clear changes them
  always_ff @(posedge clk_sys) begin
    nv <= next_nv;
  end

endmodule

/* File: testbench/sep_cmd_protect_properties.sv */
// Checker of the serial EEPROM command and protection block
`include "sep_params.svh"
module sep_cmd_protect_properties
  import sep_pkg::*;
#(
  parameter int unsigned write_cycle_len = 20
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic wp_n,
  input wire logic nv_clear,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic [7:0] status,
  input wire logic hardware_lock_mode,
  input wire logic mem_wr_start,
  input wire logic [`SEP_ADDR_W-1:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data
);
  logic [15:0] busy_cnt;
  logic [15:0] next_busy_cnt;
  logic prot;
  always_comb begin
    next_busy_cnt = (status[0] && !srst) ? busy_cnt + 16'h0001 : 16'h0000;
    prot = status[3:2] == 2'h3 || (status[3:2] == 2'h2 && mem_wr_addr[11])
      || (status[3:2] == 2'h1 && mem_wr_addr[11:10] == 2'h3);
  end
  always_ff @(posedge clk_sys) begin
    busy_cnt <= next_busy_cnt;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_status_zero_bits: assert property (status[6:4] == 3'h0)
    else $error("status bits 6 to 4 not zero");
  a_write_needs_latch: assert property (mem_wr_start |-> status[1])
    else $error("array write without latch");
  a_write_outside_protect: assert property (mem_wr_start |-> !prot)
    else $error("array write into protected block");
  a_write_sets_busy: assert property (mem_wr_start |=> status[0])
    else $error("busy flag not set by write");
  a_write_when_idle: assert property (mem_wr_start |-> !status[0])
    else $error("write started while busy");
  a_write_after_deselect: assert property (mem_wr_start |-> cs_n && $past(cs_n))
    else $error("write started while selected");
  a_latch_on_deselect: assert property ($rose(status[1]) |-> cs_n && !status[0])
    else $error("latch set while selected or busy");
  a_busy_end_clears: assert property ($fell(status[0]) |-> ##[0:1] !status[1])
    else $error("latch not cleared at cycle end");
  a_busy_length: assert property ($fell(status[0]) |-> busy_cnt >= write_cycle_len - 1
    && busy_cnt <= write_cycle_len + 2) else $error("busy length wrong");
  a_lock_needs_bit: assert property (!status[7] ##1 !status[7] |-> !hardware_lock_mode)
    else $error("lock mode without lock bit");
  a_lock_needs_pin: assert property (wp_n [*4] |-> !hardware_lock_mode)
    else $error("lock mode with pin high");
  a_output_when_selected: assert property (sdo_oe |-> !cs_n)
    else $error("output enabled while deselected");
  c_write: cover property (mem_wr_start);
  c_latch: cover property ($rose(status[1]));
  c_lock: cover property (hardware_lock_mode);
  c_read: cover property (sdo_oe);
endmodule
bind sep_cmd_protect sep_cmd_protect_properties #(.write_cycle_len(write_cycle_len))
  sep_cmd_protect_properties_inst (.clk_sys(clk_sys), .srst(srst), .sck(sck), .cs_n(cs_n),
  .sdi(sdi), .wp_n(wp_n), .nv_clear(nv_clear), .sdo(sdo), .sdo_oe(sdo_oe), .status(status),
  .hardware_lock_mode(hardware_lock_mode), .mem_wr_start(mem_wr_start),
  .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));

/* File: testbench/sep_spi_master.sv */
// Serial bus master model that drives select frames into the device
module sep_spi_master (
  output logic sck,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Sends n bits from d[31] down; rd keeps the last 16 bits seen on sdo
  task automatic frame(input logic [31:0] d, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    #37 cs_n = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      sdi = d[31 - i];
      #80 sck = 1'b1;
      rd = {rd[14:0], sdo};
      #80 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    sdi = ~sdi;
    #200;
  endtask
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench of the serial EEPROM command and protection block
`include "sep_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b0;
  logic wp_n = 1'b1;
  logic nv_clear = 1'b1;
  logic sck, cs_n, sdi, sdo, sdo_oe, hardware_lock_mode, mem_wr_start;
  logic [7:0] status;
  logic [7:0] mem_wr_data;
  logic [11:0] mem_wr_addr;
  logic [15:0] rd;
  logic [31:0] seed = 32'h0000_BBAB;
  int fails = 0;
  int check_count = 0;
  int wr_cnt = 0;
  int oe_cnt = 0;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (mem_wr_start === 1'b1) wr_cnt++;
  always @(posedge sdo_oe) oe_cnt++;
  sep_cmd_protect #(.write_cycle_len(1000)) sep_cmd_protect_inst (.clk_sys(clk_sys),
    .srst(srst), .sck(sck), .cs_n(cs_n), .sdi(sdi), .wp_n(wp_n), .nv_clear(nv_clear),
    .sdo(sdo), .sdo_oe(sdo_oe), .status(status), .hardware_lock_mode(hardware_lock_mode),
    .mem_wr_start(mem_wr_start), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));
  sep_spi_master sep_spi_master_inst (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [7:0] st(input logic [1:0] bp, input logic write_enable_latch);
    return {4'h0, bp, write_enable_latch, 1'b0};
  endfunction
  function automatic logic prot(input logic [1:0] bp, input logic [11:0] a);
    return bp == 2'h3 || (bp == 2'h2 && a[11]) || (bp == 2'h1 && a[11:10] == 2'h3);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Polls the busy flag until it drops
  task automatic wait_idle();
    int i;
    for (i = 0; i < 5000 && status[0] !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (i == 5000) begin
      fails++;
      final_report();
    end
  endtask
  task automatic cmd(input logic [31:0] d, input int n);
    sep_spi_master_inst.frame(d, n, rd);
    wait_idle();
  endtask
  initial begin
    int n0;
    logic [1:0] bp;
    logic [15:0] a;
    logic [11:0] corner [5] = '{12'hC00, 12'hBFF, 12'h800, 12'h7FF, 12'h000};
    #1 srst = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 srst = 1'b0;
    nv_clear = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(status, 8'h00);
    cmd({`SEP_OP_LATCH_SET, 24'h0}, 7);
    chk(status, 8'h00);
    cmd({`SEP_OP_LATCH_SET, 24'h0}, 9);
    chk(status, 8'h00);
    cmd({`SEP_OP_STATUS_WRITE, 8'h0C, 16'h0}, 16);
    chk(status, 8'h00);
    cmd({8'hFF, `SEP_OP_STATUS_READ, 16'h0}, 24);
    chk(16'(oe_cnt), 16'h0000);
    cmd({`SEP_OP_ARRAY_READ, 24'h0}, 32);
    chk(16'(oe_cnt), 16'h0000);
    chk(status, 8'h00);
    cmd({`SEP_OP_LATCH_SET, 24'h0}, 8);
    chk(status, 8'h02);
    cmd({`SEP_OP_LATCH_CLEAR, 24'h0}, 8);
    chk(status, 8'h00);
    for (int k = 0; k < 12; k++) begin
      seed = xs(seed);
      bp = k[1:0];
      a = (k < 5) ? {4'h0, corner[k]} : seed[15:0];
      a[15:12] = seed[19:16];
      cmd({`SEP_OP_LATCH_SET, 24'h0}, 8);
      cmd({`SEP_OP_STATUS_WRITE, 1'b0, seed[6:4], bp, seed[1:0], 16'h0}, 16);
      chk(status, st(bp, 1'b0));
      cmd({`SEP_OP_LATCH_SET, 24'h0}, 8);
      sep_spi_master_inst.frame({`SEP_OP_STATUS_READ, 24'h0}, 24, rd);
      chk(rd, {2{st(bp, 1'b1)}});
      n0 = wr_cnt;
      sep_spi_master_inst.frame({`SEP_OP_ARRAY_WRITE, a, seed[31:24]}, 32, rd);
      chk(16'(wr_cnt - n0), {15'h0, !prot(bp, a[11:0])});
      if (!prot(bp, a[11:0])) begin
        chk({4'h0, mem_wr_addr}, {4'h0, a[11:0]});
        chk(mem_wr_data, seed[31:24]);
        sep_spi_master_inst.frame({`SEP_OP_STATUS_READ, 24'h0}, 16, rd);
        chk(rd[7:0], st(bp, 1'b1) | 8'h01);
      end
      wait_idle();
      chk(status, st(bp, prot(bp, a[11:0])));
    end
    cmd({`SEP_OP_LATCH_SET, 24'h0}, 8);
    cmd({`SEP_OP_STATUS_WRITE, 8'h84, 16'h0}, 16);
    @(posedge clk_sys);
    #1 wp_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(hardware_lock_mode, 1'b1);
    cmd({`SEP_OP_LATCH_SET, 24'h0}, 8);
    cmd({`SEP_OP_STATUS_WRITE, 8'h00, 16'h0}, 16);
    chk(status[7:2], 6'h21);
    @(posedge clk_sys);
    #1 wp_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(hardware_lock_mode, 1'b0);
    cmd({`SEP_OP_LATCH_SET, 24'h0}, 8);
    cmd({`SEP_OP_STATUS_WRITE, 8'h00, 16'h0}, 16);
    chk(status, 8'h00);
    final_report();
  end
endmodule
